// ===== src/uart_addr_pkg.sv
package uart_addr_pkg;

	// --------------------------------------------------------------
	// Widths
	// --------------------------------------------------------------
	localparam int BUS_W  = 32;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int BE_W   = 4;

	// --------------------------------------------------------------
	// Register byte offsets
	// --------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_SERIAL_CONTROL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_OWN_ADDRESS    = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_ADDRESS_MASK   = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_RX_DATA        = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS     = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR      = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE     = 5'h18;

	// --------------------------------------------------------------
	// Reset values and field positions
	// --------------------------------------------------------------
	localparam logic [DATA_W-1:0] ADDR_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] MASK_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_RESET  = 8'h00;
	localparam int                IRQ_W       = 2;
	localparam int                IRQ_ACCEPT  = 0;
	localparam int                IRQ_DROP    = 1;
	localparam logic [IRQ_W-1:0]  IRQ_RESET   = 2'h0;
	localparam int                LANE0       = 0;

	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SHIFT,
		MODE_UART8,
		MODE_UART9_FIXED,
		MODE_UART9_VAR
	} serial_mode_t;

	typedef struct packed {
		logic [2:0]   reserved;
		logic         receive_flag;
		logic         received_ninth_bit;
		logic         addr_recognition_enable;
		serial_mode_t mode;
	} serial_control_t;

	localparam serial_control_t SC_RESET = 8'h00;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              ninth;
		logic              stop_ok;
	} rx_frame_t;

endpackage : uart_addr_pkg

// ===== src/addr_match.sv
module addr_match #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] i_received,
	input  wire logic [WIDTH-1:0] i_own_address,
	input  wire logic [WIDTH-1:0] i_mask,
	output logic                  o_given_hit,
	output logic                  o_broadcast_hit
);

	// Mask bit 0 is a don't care; mask bit 1 must equal the own address
	assign o_given_hit = ((i_received ^ i_own_address) & i_mask) == '0; // see [R5] [R6]

	// Ones of (address | mask) must be ones in the received byte
	assign o_broadcast_hit =
		((i_own_address | i_mask) & ~i_received) == '0; // see [R7]

endmodule : addr_match

// ===== src/uart_multiproc_address_match.sv
// What this block does
// [R1] Mode 1 with recognition uses the stop bit as the ninth bit.
// [R2] With recognition, flag rises only on address match plus valid stop (mode 1) or ninth bit one (nine-bit modes).
// [R3] Shift-register mode ignores the recognition enable completely.
// [R4] Eight-bit own address and mask registers define the given address.
// [R5] Mask bit zero makes that received address bit a don't care.
// [R6] Mask bit one requires received bit to equal own address bit.
// [R7] Broadcast is address OR mask; its ones must be ones received.
// [R8] Reset clears address and mask, so every frame matches.
// [R9] Nine-bit modes with recognition need ninth bit one plus a match.
// [R10] Nine-bit modes store the received ninth bit for software.
// [R11] All eight bits compared; given or broadcast hit accepts.
module uart_multiproc_address_match (
	input  wire logic                            i_clk,
	input  wire logic                            i_reset,
	input  wire logic [uart_addr_pkg::ADDR_W-1:0] i_avs_address,
	input  wire logic                            i_avs_read,
	input  wire logic                            i_avs_write,
	input  wire logic [uart_addr_pkg::BUS_W-1:0]  i_avs_writedata,
	input  wire logic [uart_addr_pkg::BE_W-1:0]   i_avs_byteenable,
	output logic      [uart_addr_pkg::BUS_W-1:0]  o_avs_readdata,
	output logic                                 o_avs_waitrequest,
	input  wire logic                            i_rx_valid,
	input  wire uart_addr_pkg::rx_frame_t         i_rx_frame,
	output logic                                 o_receive_flag,
	output logic                                 o_irq
);
	import uart_addr_pkg::*;

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	serial_control_t   serial_control;
	serial_control_t   next_serial_control;
	logic [DATA_W-1:0] slave_own_address;
	logic [DATA_W-1:0] next_slave_own_address;
	logic [DATA_W-1:0] slave_address_mask;
	logic [DATA_W-1:0] next_slave_address_mask;
	logic [DATA_W-1:0] rx_data;
	logic [DATA_W-1:0] next_rx_data;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  next_irq_status;
	logic [IRQ_W-1:0]  irq_enable;
	logic [IRQ_W-1:0]  next_irq_enable;
	logic              bus_ack;
	logic              next_bus_ack;
	logic [DATA_W-1:0] read_byte;
	logic [DATA_W-1:0] next_read_byte;
	logic              accept_pulse;
	logic              next_accept_pulse;

	logic              given_hit;
	logic              broadcast_hit;
	logic              recog_on;
	logic              eff_ninth;
	logic              accept;
	logic              bus_write;
	logic              lane0;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clear;
	serial_control_t   sc_write;

	// --------------------------------------------------------------
	// Address comparison
	// --------------------------------------------------------------
	addr_match #(
		.WIDTH(DATA_W)
	) u_match (
		.i_received     (i_rx_frame.data),
		.i_own_address  (slave_own_address),
		.i_mask         (slave_address_mask),
		.o_given_hit    (given_hit),
		.o_broadcast_hit(broadcast_hit)
	);

	// --------------------------------------------------------------
	// Acceptance decision
	// --------------------------------------------------------------
	// Shift mode has no address frames, so the enable is masked off here
	assign recog_on = serial_control.addr_recognition_enable
		&& (serial_control.mode != MODE_SHIFT); // see [R3]

	// Mode 1 carries no ninth bit; the stop bit stands in for it
	assign eff_ninth = (serial_control.mode == MODE_UART8)
		? i_rx_frame.stop_ok : i_rx_frame.ninth; // see [R1]

	// Address frames need the ninth bit and either kind of hit
	assign accept = !recog_on
		|| (eff_ninth && (given_hit || broadcast_hit)); // see [R2] [R9] [R11]

	// --------------------------------------------------------------
	// Bus slave
	// --------------------------------------------------------------
	// One wait state: the read byte is registered in the first cycle
	// and the request completes on the second edge.
	assign lane0     = i_avs_byteenable[LANE0];
	// Write data seen through the control layout, so no field sits bare
	assign sc_write  = serial_control_t'(i_avs_writedata[DATA_W-1:0]);
	assign bus_write = i_avs_write && bus_ack;
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack;
	assign o_avs_readdata    = {{(BUS_W - DATA_W){1'b0}}, read_byte};

	always_comb
	begin
		next_bus_ack   = (i_avs_read || i_avs_write) && !bus_ack;
		next_read_byte = BYTE_RESET;
		unique case (i_avs_address)
			OFS_SERIAL_CONTROL: next_read_byte = serial_control;
			OFS_OWN_ADDRESS:    next_read_byte = slave_own_address;
			OFS_ADDRESS_MASK:   next_read_byte = slave_address_mask;
			OFS_RX_DATA:        next_read_byte = rx_data;
			OFS_IRQ_STATUS:     next_read_byte = {{(DATA_W - IRQ_W){1'b0}},
				irq_status};
			OFS_IRQ_ENABLE:     next_read_byte = {{(DATA_W - IRQ_W){1'b0}},
				irq_enable};
			default:            next_read_byte = BYTE_RESET;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			bus_ack   <= 1'b0;
			read_byte <= BYTE_RESET;
		end
		else
		begin
			bus_ack   <= next_bus_ack;
			read_byte <= next_read_byte;
		end
	end

	// --------------------------------------------------------------
	// Configuration registers
	// --------------------------------------------------------------
	always_comb
	begin
		next_slave_own_address  = slave_own_address;
		next_slave_address_mask = slave_address_mask;
		next_irq_enable         = irq_enable;
		if (bus_write && lane0)
		begin
			if (i_avs_address == OFS_OWN_ADDRESS)
				next_slave_own_address = i_avs_writedata[DATA_W-1:0]; // see [R4]
			if (i_avs_address == OFS_ADDRESS_MASK)
				next_slave_address_mask = i_avs_writedata[DATA_W-1:0]; // see [R4]
			if (i_avs_address == OFS_IRQ_ENABLE)
				next_irq_enable = i_avs_writedata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			slave_own_address  <= ADDR_RESET; // see [R8]
			slave_address_mask <= MASK_RESET; // see [R8]
			irq_enable         <= IRQ_RESET;
		end
		else
		begin
			slave_own_address  <= next_slave_own_address;
			slave_address_mask <= next_slave_address_mask;
			irq_enable         <= next_irq_enable;
		end
	end

	// --------------------------------------------------------------
	// Serial control and receive capture
	// --------------------------------------------------------------
	always_comb
	begin
		next_serial_control = serial_control;
		next_rx_data        = rx_data;
		next_accept_pulse   = i_rx_valid && accept;
		if (bus_write && lane0 && i_avs_address == OFS_SERIAL_CONTROL)
		begin
			next_serial_control.mode = sc_write.mode;
			next_serial_control.addr_recognition_enable =
				sc_write.addr_recognition_enable;
			// Software may only clear the flag; writing one keeps it
			if (!sc_write.receive_flag)
				next_serial_control.receive_flag = 1'b0;
		end
		// A frame arriving with the clear still raises the flag
		if (i_rx_valid && accept)
		begin
			next_serial_control.receive_flag = 1'b1; // see [R2] [R9]
			next_rx_data = i_rx_frame.data;
			if (serial_control.mode != MODE_SHIFT)
				next_serial_control.received_ninth_bit = eff_ninth; // see [R10] [R1]
		end
		next_serial_control.reserved = 3'h0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			serial_control <= SC_RESET;
			rx_data        <= BYTE_RESET;
			accept_pulse   <= 1'b0;
		end
		else
		begin
			serial_control <= next_serial_control;
			rx_data        <= next_rx_data;
			accept_pulse   <= next_accept_pulse;
		end
	end

	assign o_receive_flag = serial_control.receive_flag;

	// --------------------------------------------------------------
	// Interrupts
	// --------------------------------------------------------------
	assign irq_set   = {i_rx_valid && !accept, i_rx_valid && accept};
	assign irq_clear = (bus_write && lane0 && i_avs_address == OFS_IRQ_CLEAR)
		? i_avs_writedata[IRQ_W-1:0] : IRQ_RESET;

	always_comb
	begin
		// Set wins over a clear in the same cycle
		next_irq_status = (irq_status & ~irq_clear) | irq_set;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			irq_status <= IRQ_RESET;
		else
			irq_status <= next_irq_status;
	end

	assign o_irq = |(irq_status & irq_enable);

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_frame_in;
		i_rx_valid;
	endsequence

	sequence s_addr_frame;
		s_frame_in ##0 recog_on && eff_ninth;
	endsequence

	sequence s_own_write;
		bus_write && lane0 && i_avs_address == OFS_OWN_ADDRESS;
	endsequence

	a_reset_clears_addr: assert property (disable iff (1'b0) // see [R8]
		i_reset |=> slave_own_address == ADDR_RESET
			&& slave_address_mask == MASK_RESET)
		else $error("address or mask not cleared by reset");

	a_shift_ignores_enable: assert property ( // see [R3]
		s_frame_in ##0 serial_control.mode == MODE_SHIFT
		|=> accept_pulse && serial_control.receive_flag)
		else $error("shift mode frame was filtered");

	a_stop_bit_gate: assert property ( // see [R1]
		s_frame_in ##0 recog_on && serial_control.mode == MODE_UART8
			&& !i_rx_frame.stop_ok
		|=> !accept_pulse)
		else $error("mode 1 frame without stop bit accepted");

	a_ninth_bit_gate: assert property ( // see [R9]
		s_frame_in ##0 recog_on && serial_control.mode[1]
			&& !i_rx_frame.ninth
		|=> !accept_pulse && irq_status[IRQ_DROP])
		else $error("data frame accepted under recognition");

	a_given_address_hit: assert property ( // see [R5] [R6] [R11]
		s_addr_frame ##0
			((i_rx_frame.data ^ slave_own_address) & slave_address_mask) == '0
		|=> accept_pulse ##0 rx_data == $past(i_rx_frame.data))
		else $error("given address match not accepted");

	a_broadcast_hit: assert property ( // see [R7] [R11]
		s_addr_frame ##0
			((slave_own_address | slave_address_mask)
				& ~i_rx_frame.data) == '0
		|=> accept_pulse)
		else $error("broadcast address match not accepted");

	a_no_match_drops: assert property ( // see [R2]
		s_addr_frame ##0 !given_hit && !broadcast_hit
		|=> !accept_pulse ##0 $stable(rx_data))
		else $error("mismatched address frame accepted");

	a_ninth_bit_stored: assert property ( // see [R10]
		s_frame_in ##0 accept && serial_control.mode[1]
		|=> serial_control.received_ninth_bit == $past(i_rx_frame.ninth))
		else $error("ninth bit not stored");

	a_own_addr_write: assert property ( // see [R4]
		s_own_write
		|=> slave_own_address == $past(i_avs_writedata[DATA_W-1:0]))
		else $error("own address write lost");

	a_bus_one_wait: assert property (
		(i_avs_read || i_avs_write) && !bus_ack |=> !o_avs_waitrequest)
		else $error("bus request not answered after one wait");

	a_irq_on_accept: assert property (
		accept_pulse && irq_enable[IRQ_ACCEPT] |-> o_irq ##1
			(o_irq || $past(irq_clear[IRQ_ACCEPT])
				|| !irq_enable[IRQ_ACCEPT]))
		else $error("enabled accept event gave no interrupt");

endmodule : uart_multiproc_address_match

// ===== sim/serial_master_model.sv
module serial_master_model (
	input  wire logic                     i_clk,
	input  wire logic                     i_send,
	input  wire uart_addr_pkg::rx_frame_t i_frame,
	output logic                          o_rx_valid,
	output uart_addr_pkg::rx_frame_t      o_rx_frame
);
	timeunit 1ns;
	timeprecision 100ps;
	import uart_addr_pkg::*;

	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_frame = '0;
	end

	// Frame lines are not held between frames, so a late sample sees junk
	always @(posedge i_clk)
	begin
		o_rx_valid <= i_send;
		o_rx_frame <= i_send ? i_frame : ~o_rx_frame;
	end
endmodule : serial_master_model

// ===== sim/uart_multiproc_address_match_test.sv
module uart_multiproc_address_match_test;
	timeunit 1ns;
	timeprecision 100ps;
	import uart_addr_pkg::*;

	logic              i_clk;
	logic              i_reset;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_wdata;
	logic [3:0]        avs_be;
	logic [31:0]       avs_rdata;
	logic              avs_wait;
	logic              send;
	rx_frame_t         frame_in;
	logic              rx_valid;
	rx_frame_t         rx_frame;
	logic              receive_flag;
	logic              irq;
	int                fails;
	int                checked;
	integer            seed;
	logic [31:0]       q;
	logic [31:0]       r;
	logic [7:0]        last_data;
	logic              last_ninth;

	uart_multiproc_address_match uart_multiproc_address_match_inst (
		.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be),
		.o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
		.i_rx_valid(rx_valid), .i_rx_frame(rx_frame),
		.o_receive_flag(receive_flag), .o_irq(irq));

	serial_master_model serial_master_model_inst (
		.i_clk(i_clk), .i_send(send), .i_frame(frame_in),
		.o_rx_valid(rx_valid), .o_rx_frame(rx_frame));

	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic wrap_up();
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] rq);
		int n;
		@(posedge i_clk);
		avs_read    <= !w;
		avs_write   <= w;
		avs_address <= a;
		avs_wdata   <= d;
		avs_be      <= be;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (avs_wait !== 1'b0 && n < 16);
		if (avs_wait !== 1'b0)
		begin
			fails++;
			wrap_up();
		end
		rq = avs_rdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, {24'h0, d}, 4'hF, dummy);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] rq);
		bus(1'b0, a, 32'h0, 4'hF, rq);
	endtask : rd

	function automatic logic exp_acc(input logic [1:0] m, input logic en,
		input rx_frame_t f, input logic [7:0] a, input logic [7:0] k);
		logic eff;
		eff = (m == 2'h1) ? f.stop_ok : f.ninth;
		return !(en && m != 2'h0) || (eff && ((((f.data ^ a) & k) == 8'h00)
			|| (((a | k) & ~f.data) == 8'h00)));
	endfunction : exp_acc

	task automatic run_frame(input logic [1:0] m, input logic en,
		input logic [7:0] a, input logic [7:0] k, input logic [7:0] d,
		input logic n, input logic s, input logic [1:0] ie);
		rx_frame_t   f;
		logic        acc;
		logic [31:0] rq;
		f.data    = d;
		f.ninth   = n;
		f.stop_ok = s;
		wr(OFS_OWN_ADDRESS, a);
		wr(OFS_ADDRESS_MASK, k);
		wr(OFS_IRQ_ENABLE, {6'h0, ie});
		wr(OFS_SERIAL_CONTROL, {5'h0, en, m});
		rd(OFS_ADDRESS_MASK, rq);
		chk(rq, {24'h0, k});
		chk({31'h0, receive_flag}, 32'h0);
		@(posedge i_clk);
		send     <= 1'b1;
		frame_in <= f;
		@(posedge i_clk);
		send <= 1'b0;
		repeat (3) @(posedge i_clk);
		acc = exp_acc(m, en, f, a, k);
		if (acc)
			last_data = d;
		if (acc && m != 2'h0)
			last_ninth = (m == 2'h1) ? s : n;
		chk({31'h0, receive_flag}, {31'h0, acc});
		rd(OFS_SERIAL_CONTROL, rq);
		chk(rq, {27'h0, acc, last_ninth, en, m});
		rd(OFS_RX_DATA, rq);
		chk(rq, {24'h0, last_data});
		rd(OFS_IRQ_STATUS, rq);
		chk(rq, {30'h0, !acc, acc});
		chk({31'h0, irq}, {31'h0, |({!acc, acc} & ie)});
		wr(OFS_IRQ_CLEAR, 8'h03);
		rd(OFS_IRQ_STATUS, rq);
		chk(rq | {31'h0, irq}, 32'h0);
	endtask : run_frame

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial
	begin
		seed = 32'h750B;
		fails = 0;
		checked = 0;
		last_data = 8'h00;
		last_ninth = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_wdata = 32'h0;
		avs_be = 4'h0;
		send = 1'b0;
		frame_in = '0;
		i_reset = 1'b1;
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		rd(OFS_OWN_ADDRESS, q);
		chk(q, 32'h0);
		rd(OFS_ADDRESS_MASK, q);
		chk(q, 32'h0);
		rd(5'h1C, q);
		chk(q, 32'h0);
		bus(1'b1, OFS_OWN_ADDRESS, 32'h5A, 4'hE, q);
		rd(OFS_OWN_ADDRESS, q);
		chk(q, 32'h0);
		run_frame(2'h3, 1'b1, 8'h00, 8'h00, 8'hA5, 1'b1, 1'b0, 2'h3);
		run_frame(2'h3, 1'b1, 8'h00, 8'h00, 8'hA5, 1'b0, 1'b1, 2'h3);
		run_frame(2'h2, 1'b1, 8'hF1, 8'hFA, 8'hF4, 1'b1, 1'b0, 2'h1);
		run_frame(2'h2, 1'b1, 8'hF1, 8'hFA, 8'hF2, 1'b1, 1'b1, 2'h2);
		run_frame(2'h3, 1'b1, 8'hF1, 8'hFA, 8'hFB, 1'b1, 1'b0, 2'h3);
		run_frame(2'h1, 1'b1, 8'hF3, 8'hF9, 8'hF7, 1'b1, 1'b0, 2'h3);
		run_frame(2'h1, 1'b1, 8'hF3, 8'hF9, 8'hF7, 1'b0, 1'b1, 2'h3);
		run_frame(2'h0, 1'b1, 8'hF3, 8'hF9, 8'h00, 1'b0, 1'b0, 2'h3);
		// Half the bytes are steered onto the given address to hit often
		repeat (40)
		begin
			r = $random(seed);
			q = $random(seed);
			r[31:24] = r[16] ? (r[7:0] ^ (q[7:0] & ~r[15:8])) : q[15:8];
			run_frame(r[18:17], r[19], r[7:0], r[15:8], r[31:24],
				r[20], r[21], r[23:22]);
		end
		wrap_up();
	end
endmodule : uart_multiproc_address_match_test
